// ---- core/rts_regs.sv ----
// Operation
// - Descriptor base pointer keeps a 12-bit address in bits 11..0; upper bits unused.
// - Each valid command selects one descriptor block from T/R, subaddress and mode code.
// - Descriptor base pointer stays stable while a message is being processed.
// - Host status bits (9..0 in 1553A, 9,8,3,2,0 in 1553B) appear in every status word until host clears them.
// - With auto clear enabled, host status bits clear once sent at message completion.
// - Auto clear leaves status-repeat mode codes showing the previously sent bits.
// - 1553B layout maps bits 9,8,3,2,0 to status times 10,11,16,17,19.
// - While busy is set, the block's memory accesses are blocked.
// - In 1553B, subsystem flag is sent when register bit 2 or the flag pin is active; 1553A ignores the pin.
// - A built-in test failure sets the terminal flag by itself.
// - In 1553B, inhibit mode code suppresses host terminal flag; override mode code restores it. 1553A ignores both.
// - 1553A layout with auto clear clears all status times once status is sent.
// - Sixteen illegalization registers form eight command-type blocks of two.
// - Low register bit n covers code n, high register bit n covers code 16+n.
// - Transmit and broadcast subaddress blocks use the receive block mapping.
// - Mode code blocks at indices 18..1F use the same low/high mapping.
// - A zero bit makes the command legal, a one makes it illegal.
// - Broadcast transmit subaddresses and entries marked always-illegal are forced illegal.
// - In 1553A, broadcast receive mode 00, and 02 with the option, are forced illegal.
`timescale 1ns/100ps
`default_nettype none
module rts_regs #(
  parameter int unsigned NUM_ILL = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rts_pkg::ADDR_W-1:0] paddr,
  input wire logic [rts_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rts_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_1553a,
  input wire logic tx_status_word_option,
  input wire logic msg_active,
  input wire logic cmd_valid,
  input wire logic cmd_tr,
  input wire logic cmd_broadcast,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [4:0] cmd_word_count,
  input wire logic status_sent,
  input wire logic status_repeat,
  input wire logic bit_fail,
  input wire logic subsystem_flag_pin,
  input wire logic mc_inhibit_tf,
  input wire logic mc_override_tf,
  output logic [9:0] status_time_bits,
  output logic mem_block,
  output logic cmd_illegal,
  output logic cmd_result_valid,
  output logic [15:0] descriptor_addr
);

  if (NUM_ILL != 16) begin : g_num_ill_check
    $error("rts_regs serves exactly sixteen illegalization registers");
  end

  logic [15:0] ill_reg [NUM_ILL];
  logic [11:0] desc_base_reg;
  logic [11:0] desc_pend_reg;
  logic desc_pend_valid_reg;
  logic [15:0] status_ctl_reg;
  logic bitfail_tf_reg;
  logic tf_inhibit_reg;
  logic [9:0] last_sent_reg;
  rts_pkg::rts_apb_e apb_state_reg;

  logic wr_en;
  logic [4:0] idx;
  logic [4:0] cmd_code;
  logic cmd_is_mc;
  logic [2:0] cmd_blk;
  logic [15:0] sel_word;
  logic forced_illegal;
  logic [9:0] live_status;
  logic [9:0] clear_set;

  function automatic logic reg_mapped(input logic [4:0] i);
    reg_mapped = (i == rts_pkg::IDX_DESC_BASE) || (i == rts_pkg::IDX_STATUS_CTL) ||
      (i >= rts_pkg::IDX_ILL_FIRST);
  endfunction

  function automatic logic [15:0] strobe_merge(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] strb);
    strobe_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  assign idx = paddr[6:2];
  assign wr_en = psel && penable && pready && pwrite && !pslverr;

  // Zero-wait APB slave: the answer comes in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= rts_pkg::RTS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      case (apb_state_reg)
        rts_pkg::RTS_IDLE: begin
          if (psel && !penable) begin
            apb_state_reg <= rts_pkg::RTS_ACCESS;
            pready <= 1'b1;
            pslverr <= !reg_mapped(idx) || (paddr[1:0] != 2'b00);
            prdata <= '0;
            if (!pwrite && reg_mapped(idx) && paddr[1:0] == 2'b00) begin
              if (idx == rts_pkg::IDX_DESC_BASE) begin
                prdata <= {20'h00000, desc_base_reg};
              end else if (idx == rts_pkg::IDX_STATUS_CTL) begin
                prdata <= {16'h0000, status_ctl_reg};
              end else begin
                prdata <= {16'h0000, ill_reg[idx[3:0]]};
              end
            end
          end
        end
        rts_pkg::RTS_ACCESS: begin
          apb_state_reg <= rts_pkg::RTS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          apb_state_reg <= rts_pkg::RTS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // A base pointer write during a message is held back and applied when it ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_base_reg <= '0;
      desc_pend_reg <= '0;
      desc_pend_valid_reg <= 1'b0;
    end else begin
      if (wr_en && idx == rts_pkg::IDX_DESC_BASE) begin
        if (msg_active) begin
          desc_pend_reg <= 12'(strobe_merge({4'h0, desc_base_reg}, pwdata[15:0], pstrb[1:0]) &
            rts_pkg::DESC_BASE_MASK);
          desc_pend_valid_reg <= 1'b1;
        end else begin
          desc_base_reg <= 12'(strobe_merge({4'h0, desc_base_reg}, pwdata[15:0], pstrb[1:0]) &
            rts_pkg::DESC_BASE_MASK);
          desc_pend_valid_reg <= 1'b0;
        end
      end else if (desc_pend_valid_reg && !msg_active) begin
        desc_base_reg <= desc_pend_reg;
        desc_pend_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_ILL; i++) begin
        ill_reg[i] <= rts_pkg::RESET_VALUE;
      end
    end else if (wr_en && idx >= rts_pkg::IDX_ILL_FIRST) begin
      ill_reg[idx[3:0]] <= strobe_merge(ill_reg[idx[3:0]], pwdata[15:0], pstrb[1:0]);
    end
  end

  assign clear_set = mode_1553a ? rts_pkg::CLEAR_SET_A : rts_pkg::CLEAR_SET_B;

  // Order: automatic clear, then host write, then the test-failure set, so a set is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ctl_reg <= rts_pkg::RESET_VALUE;
      bitfail_tf_reg <= 1'b0;
    end else begin
      if (status_sent && !status_repeat && status_ctl_reg[rts_pkg::BIT_AUTO_CLEAR]) begin
        status_ctl_reg[9:0] <= status_ctl_reg[9:0] & ~clear_set;
        bitfail_tf_reg <= 1'b0;
      end
      if (wr_en && idx == rts_pkg::IDX_STATUS_CTL) begin
        status_ctl_reg <= strobe_merge(status_ctl_reg, pwdata[15:0], pstrb[1:0]) &
          (mode_1553a ? rts_pkg::STATUS_MASK_A : rts_pkg::STATUS_MASK_B);
        if (pstrb[0] && !pwdata[rts_pkg::BIT_TERM]) begin
          bitfail_tf_reg <= 1'b0;
        end
      end
      if (bit_fail) begin
        status_ctl_reg[rts_pkg::BIT_TERM] <= 1'b1;
        bitfail_tf_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_inhibit_reg <= 1'b0;
    end else if (mc_inhibit_tf) begin
      tf_inhibit_reg <= 1'b1;
    end else if (mc_override_tf) begin
      tf_inhibit_reg <= 1'b0;
    end
  end

  always_comb begin
    if (mode_1553a) begin
      live_status = status_ctl_reg[9:0];
    end else begin
      live_status = '0;
      live_status[rts_pkg::BIT_INSTR] = status_ctl_reg[rts_pkg::BIT_INSTR];
      live_status[rts_pkg::BIT_SRQ] = status_ctl_reg[rts_pkg::BIT_SRQ];
      live_status[rts_pkg::BIT_BUSY] = status_ctl_reg[rts_pkg::BIT_BUSY];
      live_status[rts_pkg::BIT_SUBSYS] = status_ctl_reg[rts_pkg::BIT_SUBSYS] |
        subsystem_flag_pin;
      live_status[rts_pkg::BIT_TERM] = (status_ctl_reg[rts_pkg::BIT_TERM] & !tf_inhibit_reg) |
        bitfail_tf_reg;
    end
  end

  // Repeat mode codes answer with the bits last sent, so clearing cannot lose them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sent_reg <= '0;
      status_time_bits <= '0;
      mem_block <= 1'b0;
    end else begin
      if (status_sent && !status_repeat) begin
        last_sent_reg <= status_time_bits;
      end
      status_time_bits <= status_repeat ? last_sent_reg : live_status;
      mem_block <= status_ctl_reg[rts_pkg::BIT_BUSY];
    end
  end

  assign cmd_is_mc = (cmd_subaddr == rts_pkg::MC_SA_LOW) || (cmd_subaddr == rts_pkg::MC_SA_HIGH);
  assign cmd_code = cmd_is_mc ? cmd_word_count : cmd_subaddr;
  assign cmd_blk = {cmd_is_mc, cmd_broadcast, cmd_tr};
  assign sel_word = ill_reg[{cmd_blk, cmd_code[4]}];

  always_comb begin
    forced_illegal = 1'b0;
    if (cmd_blk == rts_pkg::BLK_BTX_SA) begin
      forced_illegal = 1'b1;
    end
    if (cmd_blk == rts_pkg::BLK_BTX_MC) begin
      if (cmd_code == rts_pkg::MC_BTX_ALWAYS) begin
        forced_illegal = 1'b1;
      end
      if (cmd_code[4] && !mode_1553a) begin
        forced_illegal = 1'b1;
      end
    end
    if (cmd_blk == rts_pkg::BLK_BRX_MC && mode_1553a) begin
      if (cmd_code == rts_pkg::MC_BCAST_A_AUTO) begin
        forced_illegal = 1'b1;
      end
      if (cmd_code == rts_pkg::MC_BCAST_A_TX_STATUS_WORD_OPTION && tx_status_word_option) begin
        forced_illegal = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_illegal <= 1'b0;
      cmd_result_valid <= 1'b0;
      descriptor_addr <= '0;
    end else begin
      cmd_result_valid <= cmd_valid;
      if (cmd_valid) begin
        cmd_illegal <= sel_word[cmd_code[3:0]] | forced_illegal;
        descriptor_addr <= 16'({4'h0, desc_base_reg} + {7'h00, (cmd_is_mc ? rts_pkg::DESC_OFS_MC :
          9'h000)} + {7'h00, (cmd_tr ? rts_pkg::DESC_OFS_TX : 9'h000)} +
          {9'h000, cmd_code, 2'b00});
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("APB answer not given in first access cycle");
  chk_base_static: assert property (msg_active && $past(msg_active) |-> $stable(desc_base_reg))
    else $error("Descriptor base changed during a message");
  chk_base_width: assert property (wr_en && idx == rts_pkg::IDX_DESC_BASE && !msg_active &&
    pstrb[1:0] == 2'b11 |=> desc_base_reg == $past(pwdata[11:0]))
    else $error("Descriptor base not stored from bits 11..0");
  chk_bitfail_tf: assert property (bit_fail ##1 !status_repeat |=> status_time_bits[0])
    else $error("Test failure did not raise terminal flag");
  chk_busy_block: assert property (status_ctl_reg[rts_pkg::BIT_BUSY] |=> mem_block)
    else $error("Busy set but memory not blocked");
  chk_ssf_pin: assert property (subsystem_flag_pin && !mode_1553a && !status_repeat |=>
    status_time_bits[rts_pkg::BIT_SUBSYS])
    else $error("Subsystem flag pin not reflected");
  chk_auto_clear: assert property (status_sent && !status_repeat && !wr_en && !bit_fail &&
    status_ctl_reg[rts_pkg::BIT_AUTO_CLEAR] |=> (status_ctl_reg[9:0] & $past(clear_set)) == 0)
    else $error("Automatic clear missed");
  chk_hold_bits: assert property (!status_ctl_reg[rts_pkg::BIT_AUTO_CLEAR] && !wr_en |=>
    status_ctl_reg[9:0] == ($past(status_ctl_reg[9:0]) | {9'h000, $past(bit_fail)}))
    else $error("Status bits changed without host write");
  chk_btx_illegal: assert property (cmd_valid && cmd_blk == rts_pkg::BLK_BTX_SA |=> cmd_illegal)
    else $error("Broadcast transmit subaddress accepted");
  chk_ill_map: assert property (cmd_valid && !forced_illegal |=>
    cmd_illegal == $past(sel_word[cmd_code[3:0]]))
    else $error("Illegalization bit not applied");
  chk_repeat_kept: assert property (status_repeat |=> status_time_bits == $past(last_sent_reg))
    else $error("Repeat mode code lost sent bits");

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready held for more than one cycle");
  chk_ready_idle: assert property (!psel |=> !pready)
    else $error("Ready raised without a setup cycle");
  chk_err_unmapped: assert property (psel && !penable && !reg_mapped(idx) |=>
    pslverr && prdata == '0)
    else $error("Unmapped index not refused");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("Error response outside the access cycle");
  chk_base_read_top: assert property (psel && !penable && !pwrite &&
    idx == rts_pkg::IDX_DESC_BASE |=> prdata[31:12] == '0)
    else $error("Descriptor base read shows bits above 11");
  chk_status_unused: assert property (
    (status_ctl_reg & ~rts_pkg::STATUS_MASK_A) == '0)
    else $error("Unused status control bits set");
  chk_ill_write: assert property (wr_en && idx >= rts_pkg::IDX_ILL_FIRST &&
    pstrb[1:0] == 2'b11 |=> ill_reg[$past(idx[3:0])] == $past(pwdata[15:0]))
    else $error("Illegalization register write lost");
  chk_pend_apply: assert property (desc_pend_valid_reg && !msg_active &&
    !(wr_en && idx == rts_pkg::IDX_DESC_BASE) |=> desc_base_reg == $past(desc_pend_reg))
    else $error("Held base pointer not applied after the message");
  chk_pend_hold: assert property (desc_pend_valid_reg && msg_active |=>
    desc_pend_valid_reg)
    else $error("Held base pointer dropped during the message");
  chk_busy_release: assert property (!status_ctl_reg[rts_pkg::BIT_BUSY] |=>
    !mem_block)
    else $error("Memory still blocked after busy cleared");
  chk_result_pulse: assert property (cmd_valid |=> cmd_result_valid)
    else $error("Command result not flagged");
  chk_result_quiet: assert property (!cmd_valid |=> !cmd_result_valid &&
    $stable(cmd_illegal) && $stable(descriptor_addr))
    else $error("Command result changed without a command");
  chk_desc_rx_sa: assert property (cmd_valid && !cmd_is_mc && !cmd_tr |=>
    descriptor_addr == 16'({4'h0, $past(desc_base_reg)} +
    {9'h000, $past(cmd_subaddr), 2'b00}))
    else $error("Receive subaddress descriptor address wrong");
  chk_brx_mc_auto: assert property (cmd_valid && cmd_blk == rts_pkg::BLK_BRX_MC &&
    mode_1553a && cmd_code == rts_pkg::MC_BCAST_A_AUTO |=> cmd_illegal)
    else $error("Broadcast receive mode code 00 accepted in 1553A");
  chk_btx_mc_high: assert property (cmd_valid && cmd_blk == rts_pkg::BLK_BTX_MC &&
    !mode_1553a && cmd_code[4] |=> cmd_illegal)
    else $error("High broadcast transmit mode code accepted in 1553B");
  chk_layout_b: assert property (!mode_1553a && !status_repeat |=>
    (status_time_bits & ~rts_pkg::CLEAR_SET_B) == '0)
    else $error("Unmapped status time set in 1553B layout");
  chk_layout_a: assert property (mode_1553a && !status_repeat |=>
    status_time_bits == $past(status_ctl_reg[9:0]))
    else $error("Status times do not follow bits in 1553A layout");
  chk_inhibit_tf: assert property (mc_inhibit_tf |=> tf_inhibit_reg)
    else $error("Inhibit mode code not latched");
  chk_override_tf: assert property (mc_override_tf && !mc_inhibit_tf |=>
    !tf_inhibit_reg)
    else $error("Override mode code did not restore the flag");
  chk_a_clear_all: assert property (mode_1553a && status_sent && !status_repeat &&
    !wr_en && !bit_fail && status_ctl_reg[rts_pkg::BIT_AUTO_CLEAR] |=>
    status_ctl_reg[9:0] == '0)
    else $error("1553A automatic clear left status times set");
  chk_last_copy: assert property (status_sent && !status_repeat |=>
    last_sent_reg == $past(status_time_bits))
    else $error("Sent status not kept for repeat mode codes");
  chk_bitfail_set: assert property (bit_fail |=>
    status_ctl_reg[rts_pkg::BIT_TERM] && bitfail_tf_reg)
    else $error("Test failure set lost against a clear");

endmodule
`default_nettype wire

// ---- core/rts_pkg.sv ----
package rts_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [4:0] IDX_DESC_BASE = 5'h08;
  localparam logic [4:0] IDX_STATUS_CTL = 5'h09;
  localparam logic [4:0] IDX_ILL_FIRST = 5'h10;
  localparam logic [4:0] IDX_RX_SA_LO = 5'h10;
  localparam logic [4:0] IDX_RX_SA_HI = 5'h11;
  localparam logic [4:0] IDX_TX_SA_LO = 5'h12;
  localparam logic [4:0] IDX_TX_SA_HI = 5'h13;
  localparam logic [4:0] IDX_BRX_SA_LO = 5'h14;
  localparam logic [4:0] IDX_BRX_SA_HI = 5'h15;
  localparam logic [4:0] IDX_BTX_SA_LO = 5'h16;
  localparam logic [4:0] IDX_BTX_SA_HI = 5'h17;
  localparam logic [4:0] IDX_RX_MC_LO = 5'h18;
  localparam logic [4:0] IDX_RX_MC_HI = 5'h19;
  localparam logic [4:0] IDX_TX_MC_LO = 5'h1A;
  localparam logic [4:0] IDX_TX_MC_HI = 5'h1B;
  localparam logic [4:0] IDX_BRX_MC_LO = 5'h1C;
  localparam logic [4:0] IDX_BRX_MC_HI = 5'h1D;
  localparam logic [4:0] IDX_BTX_MC_LO = 5'h1E;
  localparam logic [4:0] IDX_BTX_MC_HI = 5'h1F;
  localparam logic [15:0] DESC_BASE_MASK = 16'h0FFF;
  localparam logic [15:0] STATUS_MASK_B = 16'h830D;
  localparam logic [15:0] STATUS_MASK_A = 16'h83FF;
  localparam int unsigned BIT_AUTO_CLEAR = 15;
  localparam int unsigned BIT_INSTR = 9;
  localparam int unsigned BIT_SRQ = 8;
  localparam int unsigned BIT_BUSY = 3;
  localparam int unsigned BIT_SUBSYS = 2;
  localparam int unsigned BIT_TERM = 0;
  localparam logic [9:0] CLEAR_SET_B = 10'h30D;
  localparam logic [9:0] CLEAR_SET_A = 10'h3FF;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [4:0] MC_SA_LOW = 5'h00;
  localparam logic [4:0] MC_SA_HIGH = 5'h1F;
  localparam logic [4:0] MC_BCAST_A_AUTO = 5'h00;
  localparam logic [4:0] MC_BCAST_A_TX_STATUS_WORD_OPTION = 5'h02;
  localparam logic [4:0] MC_BTX_ALWAYS = 5'h00;
  localparam logic [8:0] DESC_OFS_TX = 9'h080;
  localparam logic [8:0] DESC_OFS_MC = 9'h100;
  localparam logic [2:0] BLK_BTX_SA = 3'h3;
  localparam logic [2:0] BLK_BRX_MC = 3'h6;
  localparam logic [2:0] BLK_BTX_MC = 3'h7;
  typedef enum logic [1:0] {
    RTS_IDLE = 2'b00,
    RTS_ACCESS = 2'b01
  } rts_apb_e;
endpackage

// ---- bench/rts_bc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module rts_bc_model (
  input wire logic pclk,
  output logic cmd_valid,
  output logic cmd_tr,
  output logic cmd_broadcast,
  output logic [4:0] cmd_subaddr,
  output logic [4:0] cmd_word_count,
  output logic msg_active,
  output logic status_repeat,
  output logic [3:0] pulses
);
  initial begin
    {cmd_valid, cmd_tr, cmd_broadcast, cmd_subaddr, cmd_word_count} = '0;
    {msg_active, status_repeat, pulses} = '0;
  end
  // Fields are inverted once the strobe drops, so a late sample cannot match by luck.
  task automatic send(input logic tr, input logic b, input logic [4:0] sa, input logic [4:0] wc);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_tr <= tr;
    cmd_broadcast <= b;
    cmd_subaddr <= sa;
    cmd_word_count <= wc;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_tr <= ~tr;
    cmd_broadcast <= ~b;
    cmd_subaddr <= ~sa;
    cmd_word_count <= ~wc;
  endtask
  task automatic pulse(input int k);
    @(posedge pclk);
    pulses[k] <= 1'b1;
    @(posedge pclk);
    pulses[k] <= 1'b0;
  endtask
  task automatic level(input logic act, input logic rep);
    @(posedge pclk);
    msg_active <= act;
    status_repeat <= rep;
  endtask
endmodule
`default_nettype wire

// ---- bench/rt_status_and_illegalization_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module rt_status_and_illegalization_regs_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] alow = 2'b00;
  logic mode_a = 1'b0, opt = 1'b0, ss_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cv, ctr, cbc, act, rep, ill, crv, mblk, e;
  logic [4:0] csa, cwc;
  logic [3:0] pls;
  logic [9:0] sbits;
  logic [15:0] daddr, r;
  logic [15:0] mdl [32];
  int fail_count = 0, compares = 0, cyc = 0, n;
  integer seed = 32'h86714466;
  always #25 pclk = ~pclk;
  rts_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_1553a(mode_a), .tx_status_word_option(opt),
    .msg_active(act), .cmd_valid(cv), .cmd_tr(ctr), .cmd_broadcast(cbc), .cmd_subaddr(csa),
    .cmd_word_count(cwc), .status_sent(pls[0]), .status_repeat(rep), .bit_fail(pls[3]),
    .subsystem_flag_pin(ss_pin), .mc_inhibit_tf(pls[1]), .mc_override_tf(pls[2]),
    .status_time_bits(sbits), .mem_block(mblk), .cmd_illegal(ill), .cmd_result_valid(crv),
    .descriptor_addr(daddr));
  rts_bc_model bus (.pclk(pclk), .cmd_valid(cv), .cmd_tr(ctr), .cmd_broadcast(cbc),
    .cmd_subaddr(csa), .cmd_word_count(cwc), .msg_active(act), .status_repeat(rep),
    .pulses(pls));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] msk(input logic [4:0] i);
    if (i == 5'h08) return rts_pkg::DESC_BASE_MASK;
    if (i == 5'h09) return mode_a ? rts_pkg::STATUS_MASK_A : rts_pkg::STATUS_MASK_B;
    return 16'hFFFF;
  endfunction
  function automatic logic [4:0] mp(input int j);
    return (j < 2) ? 5'(8 + j) : 5'(14 + j);
  endfunction
  task automatic apb(input logic w, input logic [4:0] i, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, i, alow};
    pwdata <= {16'($random(seed)), d};
    pstrb <= wstrb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(32'(pready), 32'h1);
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && e === 1'b0) mdl[i] = {wstrb[1] ? d[15:8] : mdl[i][15:8],
      wstrb[0] ? d[7:0] : mdl[i][7:0]} & msk(i);
  endtask
  task automatic rd(input logic [4:0] i);
    apb(1'b0, i, 16'h0000);
    chk(32'(r), 32'(mdl[i]));
  endtask
  task automatic st(input logic [9:0] x);
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(sbits), 32'(x));
  endtask
  task automatic cmd(input logic tr, input logic b, input logic mc, input logic [4:0] c);
    logic x;
    @(posedge pclk);
    opt <= 1'($random(seed));
    bus.send(tr, b, mc ? {5{1'($random(seed))}} : c, mc ? c : 5'($random(seed)));
    x = mdl[{1'b1, mc, b, tr, c[4]}][c[3:0]];
    x |= tr && b && (!mc || c == 5'h00 || (!mode_a && c[4]));
    x |= mode_a && mc && b && !tr && (c == 5'h00 || (c == 5'h02 && opt));
    #1;
    n = 0;
    while (crv !== 1'b1 && n < 8) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(crv), 32'h1);
    chk(32'(ill), 32'(x));
    chk(32'(daddr), 32'(mdl[8] + {7'h0, mc, tr, c, 2'b00}));
  endtask
  // The ceiling is several times the expected run, so only a real hang reaches it.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    for (int i = 0; i < 32; i++) mdl[i] = 16'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 0; j < 18; j++) rd(mp(j));
    apb(1'b1, 5'h0A, 16'hFFFF);
    chk(32'(e), 32'h1);
    apb(1'b0, 5'h0A, 16'h0000);
    chk(32'({e, r}), 32'h10000);
    alow = 2'b10;
    apb(1'b1, 5'h08, 16'h0FFF);
    chk(32'(e), 32'h1);
    alow = 2'b00;
    rd(5'h08);
    for (int j = 0; j < 18; j++) begin
      wstrb = 4'($random(seed));
      apb(1'b1, mp(j), 16'($random(seed)));
      rd(mp(j));
    end
    wstrb = 4'hF;
    apb(1'b1, 5'h09, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      mode_a <= m[0];
      for (int b = 0; b < 8; b++)
        for (int c = 0; c < 32; c++)
          if (b[2] || (c != 0 && c != 31)) cmd(b[0], b[1], b[2], 5'(c));
    end
    @(posedge pclk);
    mode_a <= 1'b0;
    apb(1'b1, 5'h08, 16'h0100);
    bus.level(1'b1, 1'b0);
    apb(1'b1, 5'h08, 16'h0200);
    mdl[8] = 16'h0100;
    cmd(1'b0, 1'b0, 1'b0, 5'h05);
    bus.level(1'b0, 1'b0);
    mdl[8] = 16'h0200;
    repeat (2) @(posedge pclk);
    cmd(1'b1, 1'b0, 1'b1, 5'h11);
    apb(1'b1, 5'h09, 16'h030D);
    st(10'h30D);
    chk(32'(mblk), 32'h1);
    bus.pulse(0);
    st(10'h30D);
    apb(1'b1, 5'h09, 16'h0000);
    st(10'h000);
    chk(32'(mblk), 32'h0);
    @(posedge pclk);
    ss_pin <= 1'b1;
    st(10'h004);
    @(posedge pclk);
    ss_pin <= 1'b0;
    apb(1'b1, 5'h09, 16'h0001);
    bus.pulse(1);
    st(10'h000);
    bus.pulse(2);
    st(10'h001);
    apb(1'b1, 5'h09, 16'h0000);
    bus.pulse(3);
    st(10'h001);
    apb(1'b1, 5'h09, 16'h0000);
    st(10'h000);
    apb(1'b1, 5'h09, 16'h8200);
    st(10'h200);
    bus.pulse(0);
    st(10'h000);
    bus.level(1'b0, 1'b1);
    st(10'h200);
    bus.level(1'b0, 1'b0);
    mdl[9] = 16'h8000;
    rd(5'h09);
    @(posedge pclk);
    mode_a <= 1'b1;
    apb(1'b1, 5'h09, 16'h82A5);
    st(10'h2A5);
    bus.pulse(0);
    st(10'h000);
    mdl[9] = 16'h8000;
    rd(5'h09);
    tally_and_finish();
  end
endmodule
`default_nettype wire
